// File: hdtx_defs.svh
// Constants for the HDLC transmit packet FIFO: register indices,
// field positions, reset values and line coding constants.
// Assumes inclusion by bare name from the design files.
`ifndef HDTX_DEFS_SVH
`define HDTX_DEFS_SVH
// Register indices; byte address is four times the index
`define HDTX_IDX_CTRL 10'h0A0
`define HDTX_IDX_PORT 10'h0A2
`define HDTX_IDX_STAT 10'h0A4
`define HDTX_IDX_LAT 10'h0A6
`define HDTX_IDX_IEN 10'h0A8
`define HDTX_IDX_GIE 10'h0AA
`define HDTX_CTRL_RESET 16'h0800
`define HDTX_CTRL_MASK 16'h1F7F
`define HDTX_THR_HI 12
`define HDTX_THR_LO 8
`define HDTX_PSD_BIT 6
`define HDTX_FEI_BIT 5
`define HDTX_IFV_BIT 4
`define HDTX_BRE_BIT 3
`define HDTX_INV_BIT 2
`define HDTX_FPD_BIT 1
`define HDTX_FRST_BIT 0
`define HDTX_END_BIT 0
`define HDTX_BYTE_HI 15
`define HDTX_BYTE_LO 8
`define HDTX_LAT_W 6
`define HDTX_FLAG 8'h7E
`define HDTX_CRC_POLY 16'h8408
`define HDTX_CRC_PRESET 16'hFFFF
`define HDTX_STUFF_RUN 3'h5
`define HDTX_FCS_LAST 4'hF
`define HDTX_RESP_OKAY 2'h0
`define HDTX_RESP_SLVERR 2'h2
`define HDTX_POWERUP_CYCLES 16
`endif

// File: hdtx_pkg.sv
// Types for the HDLC transmit packet FIFO.
// Assumes nothing beyond a SystemVerilog compiler.
package hdtx_pkg;
  typedef enum logic [4:0] {
    HDTX_S_FILL = 5'h01,
    HDTX_S_OPEN = 5'h02,
    HDTX_S_DATA = 5'h04,
    HDTX_S_FCS = 5'h08,
    HDTX_S_CLOSE = 5'h10
  } hdtx_state_t;
endpackage

// File: hdtx_packet_fifo.sv
// HDLC transmit packet FIFO: AXI4-Lite register slave, byte FIFO and
// bit-serial packet processor toward the line framer.
// Assumes the framer runs on aclk and takes one bit per cycle of tx_bit_ready.
`timescale 1ns/10ps
`include "hdtx_defs.svh"
module hdtx_packet_fifo
  import hdtx_pkg::*;
#(
  parameter int FIFO_DEPTH = 256,
  parameter int POWERUP_CYCLES = `HDTX_POWERUP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_bit_ready,
  output logic tx_bit,
  output logic tx_bit_valid,
  output logic irq
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_N = CW'(FIFO_DEPTH);
  localparam logic [15:0] CTRL_MASK = `HDTX_CTRL_MASK;
  localparam logic [7:0] FLAG = `HDTX_FLAG;

  if (FIFO_DEPTH != (1 << AW) || FIFO_DEPTH < 8 || FIFO_DEPTH > 256 || POWERUP_CYCLES < 1) begin : g_bad
    $error("hdtx_packet_fifo: unsupported parameter value");
  end

  function automatic logic [15:0] hdtx_crc_step(input logic [15:0] c, input logic b);
    hdtx_crc_step = (c >> 1) ^ ((c[0] ^ b) ? `HDTX_CRC_POLY : 16'h0000);
  endfunction

  // Register bus state
  logic aw_full;
  logic w_full;
  logic [9:0] aw_idx;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  logic [15:0] ctrl;
  logic [`HDTX_LAT_W-1:0] lat;
  logic [`HDTX_LAT_W-1:0] irq_en;
  logic port_irq_en;
  logic end_hold;

  // FIFO state
  logic [8:0] mem [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [15:0] pwr_cnt;
  logic frst_q;
  logic empty_q;
  logic space_q;
  logic full_q;

  // Serializer state
  hdtx_state_t state;
  hdtx_state_t next_state;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic [2:0] ones;
  logic [2:0] next_ones;
  logic [15:0] crc;
  logic [15:0] next_crc;
  logic [15:0] fcs_sr;
  logic [15:0] next_fcs_sr;
  logic [3:0] fcs_cnt;
  logic [3:0] next_fcs_cnt;
  logic [8:0] cur;
  logic [8:0] next_cur;
  logic pop;
  logic underrun;
  logic raw_bit;

  // Control fields
  wire [4:0] thr = ctrl[`HDTX_THR_HI:`HDTX_THR_LO];
  wire psd = ctrl[`HDTX_PSD_BIT];
  wire fei = ctrl[`HDTX_FEI_BIT];
  wire ifv = ctrl[`HDTX_IFV_BIT];
  wire bre = ctrl[`HDTX_BRE_BIT];
  wire inv = ctrl[`HDTX_INV_BIT];
  wire fpd = ctrl[`HDTX_FPD_BIT];
  wire frst = ctrl[`HDTX_FRST_BIT];

  // Write channel decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire wr_ctrl = do_write && aw_idx == `HDTX_IDX_CTRL;
  wire wr_port = do_write && aw_idx == `HDTX_IDX_PORT;
  wire wr_lat = do_write && aw_idx == `HDTX_IDX_LAT;
  wire wr_ien = do_write && aw_idx == `HDTX_IDX_IEN;
  wire wr_gie = do_write && aw_idx == `HDTX_IDX_GIE;
  wire wr_stat = do_write && aw_idx == `HDTX_IDX_STAT;
  wire wr_map = wr_ctrl | wr_port | wr_lat | wr_ien | wr_gie | wr_stat;
  wire next_aw_full = do_write ? 1'b0 : (aw_full | aw_take);
  wire next_w_full = do_write ? 1'b0 : (w_full | w_take);
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

  // FIFO status
  wire full = count == DEPTH_N;
  wire empty = count == '0;
  wire [CW-1:0] free = DEPTH_N - count;
  wire [5:0] free_group_count = 6'(free >> 3);
  wire space_available_flag = 9'(free) > {1'b0, thr, 3'h0};
  wire powered = pwr_cnt == 16'h0000;
  wire frst_fall = frst_q & ~frst;
  wire [8:0] head = mem[rd_ptr];

  // Byte loads only on the upper lane; a lone low-lane write just parks the marker
  wire push_req = wr_port && w_strb[1];
  wire push_end = w_strb[0] ? w_data[`HDTX_END_BIT] : end_hold;
  wire accept = push_req && !frst && powered;
  wire push = accept && !full;
  wire overflow_ev = accept && full;

  // Read channel decode
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [9:0] ar_idx = s_axi_araddr[11:2];
  wire [15:0] status = {2'h0, free_group_count, 5'h00, full, empty, space_available_flag};
  wire rd_ctrl = ar_idx == `HDTX_IDX_CTRL;
  wire rd_port = ar_idx == `HDTX_IDX_PORT;
  wire rd_stat = ar_idx == `HDTX_IDX_STAT;
  wire rd_lat = ar_idx == `HDTX_IDX_LAT;
  wire rd_ien = ar_idx == `HDTX_IDX_IEN;
  wire rd_gie = ar_idx == `HDTX_IDX_GIE;
  wire rd_map = rd_ctrl | rd_port | rd_stat | rd_lat | rd_ien | rd_gie;
  wire [15:0] rd_val = rd_ctrl ? ctrl :
                       rd_stat ? status :
                       rd_lat ? {10'h000, lat} :
                       rd_ien ? {10'h000, irq_en} :
                       rd_gie ? {15'h0000, port_irq_en} :
                       16'h0000;
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Serializer helpers
  wire step = tx_bit_ready && tx_bit_valid;
  wire byte_end = bitcnt == 3'h7;
  wire in_body = state == HDTX_S_DATA || state == HDTX_S_FCS;
  wire stuff = (in_body || state == HDTX_S_CLOSE) && ones == `HDTX_STUFF_RUN;
  wire [2:0] bidx = bre ? 3'h7 - bitcnt : bitcnt;
  wire data_bit = cur[bidx];
  wire flag_bit = FLAG[bitcnt];
  wire [15:0] crc_new = hdtx_crc_step(crc, data_bit);
  wire can_start = !empty && !psd && powered;
  wire [15:0] fcs_val = fei ? crc_new : ~crc_new;
  wire pkt_end_ev = pop && head[8];

  // Latched events; set wins over a same-cycle software clear
  wire [`HDTX_LAT_W-1:0] lat_set = {
    overflow_ev,
    underrun,
    pkt_end_ev,
    full & ~full_q,
    (empty & ~empty_q) | frst_fall,
    (space_available_flag & ~space_q) | frst_fall
  };
  wire [`HDTX_LAT_W-1:0] lat_clr = (wr_lat && w_strb[0]) ? w_data[`HDTX_LAT_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 10'h000;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HDTX_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready <= ~next_w_full;
      s_axi_bvalid <= next_bvalid;
      if (aw_take) begin
        aw_idx <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        w_data <= s_axi_wdata[15:0];
        w_strb <= s_axi_wstrb[1:0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_map ? `HDTX_RESP_OKAY : `HDTX_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `HDTX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= {16'h0000, rd_val};
        s_axi_rresp <= rd_map ? `HDTX_RESP_OKAY : `HDTX_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `HDTX_CTRL_RESET;
      irq_en <= '0;
      port_irq_en <= 1'b0;
      end_hold <= 1'b0;
      lat <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl && w_strb[0]) begin
        ctrl[7:0] <= w_data[7:0] & CTRL_MASK[7:0];
      end
      if (wr_ctrl && w_strb[1]) begin
        ctrl[15:8] <= w_data[15:8] & CTRL_MASK[15:8];
      end
      if (wr_ien && w_strb[0]) begin
        irq_en <= w_data[`HDTX_LAT_W-1:0];
      end
      if (wr_gie && w_strb[0]) begin
        port_irq_en <= w_data[0];
      end
      if (wr_port && w_strb[0]) begin
        end_hold <= w_data[`HDTX_END_BIT];
      end
      lat <= (lat & ~lat_clr) | lat_set;
      irq <= port_irq_en && |(lat & irq_en);
    end
  end

  // Memory has no reset; pointers alone define its contents
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= {push_end, w_data[`HDTX_BYTE_HI:`HDTX_BYTE_LO]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || frst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      pwr_cnt <= 16'(POWERUP_CYCLES);
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
      if (!powered) begin
        pwr_cnt <= pwr_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frst_q <= 1'b0;
      empty_q <= 1'b1;
      space_q <= 1'b1;
      full_q <= 1'b0;
    end else begin
      frst_q <= frst;
      empty_q <= empty;
      space_q <= space_available_flag;
      full_q <= full;
    end
  end

  always_comb begin
    raw_bit = 1'b1;
    unique case (state)
      HDTX_S_FILL: raw_bit = ifv | flag_bit;
      HDTX_S_OPEN: raw_bit = flag_bit;
      HDTX_S_CLOSE: raw_bit = flag_bit;
      HDTX_S_DATA: raw_bit = !stuff && data_bit;
      HDTX_S_FCS: raw_bit = !stuff && fcs_sr[0];
    endcase
  end

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_ones = ones;
    next_crc = crc;
    next_fcs_sr = fcs_sr;
    next_fcs_cnt = fcs_cnt;
    next_cur = cur;
    pop = 1'b0;
    underrun = 1'b0;
    if (step) begin
      next_bitcnt = bitcnt + 3'h1;
      unique case (state)
        HDTX_S_FILL: begin
          next_ones = 3'h0;
          if (byte_end && can_start) begin
            next_state = HDTX_S_OPEN;
          end
        end
        HDTX_S_OPEN, HDTX_S_CLOSE: begin
          next_ones = 3'h0;
          if (stuff) begin
            // A run of five ones that ends the body still needs its zero before the flag
            next_bitcnt = bitcnt;
          end else if (byte_end) begin
            // A closing flag doubles as the next opening one for back-to-back packets
            if (state == HDTX_S_OPEN || can_start) begin
              next_state = HDTX_S_DATA;
              pop = 1'b1;
              next_cur = head;
              next_crc = `HDTX_CRC_PRESET;
            end else begin
              next_state = HDTX_S_FILL;
            end
          end
        end
        HDTX_S_DATA: begin
          if (stuff) begin
            next_ones = 3'h0;
            next_bitcnt = bitcnt;
          end else begin
            next_ones = data_bit ? ones + 3'h1 : 3'h0;
            next_crc = crc_new;
            if (byte_end) begin
              if (cur[8]) begin
                next_state = fpd ? HDTX_S_CLOSE : HDTX_S_FCS;
                next_fcs_sr = fcs_val;
                next_fcs_cnt = 4'h0;
              end else if (!empty) begin
                pop = 1'b1;
                next_cur = head;
              end else begin
                // Starved: the frame is cut short with a flag and its data is lost
                underrun = 1'b1;
                next_state = HDTX_S_CLOSE;
              end
            end
          end
        end
        HDTX_S_FCS: begin
          if (stuff) begin
            next_ones = 3'h0;
            next_bitcnt = bitcnt;
          end else begin
            next_ones = fcs_sr[0] ? ones + 3'h1 : 3'h0;
            next_fcs_sr = fcs_sr >> 1;
            next_fcs_cnt = fcs_cnt + 4'h1;
            if (fcs_cnt == `HDTX_FCS_LAST) begin
              next_state = HDTX_S_CLOSE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || frst) begin
      state <= HDTX_S_FILL;
      bitcnt <= 3'h0;
      ones <= 3'h0;
      crc <= `HDTX_CRC_PRESET;
      fcs_sr <= 16'h0000;
      fcs_cnt <= 4'h0;
      cur <= 9'h000;
      tx_bit <= 1'b1;
      tx_bit_valid <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      ones <= next_ones;
      crc <= next_crc;
      fcs_sr <= next_fcs_sr;
      fcs_cnt <= next_fcs_cnt;
      cur <= next_cur;
      tx_bit_valid <= 1'b1;
      if (step) begin
        tx_bit <= raw_bit ^ inv;
      end
    end
  end
endmodule

// File: hdtx_checker.sv
// Port assertions for the HDLC transmit packet FIFO.
// Assumes it is bound into the block: one clock, synchronous active-low reset.
`timescale 1ns/10ps
module hdtx_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_bit_ready,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset itself is the cause here, so this one cannot be disabled by it
  rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !tx_bit_valid && !irq)
    else $error("outputs not idle after reset");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two edges after handshake");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one edge after handshake");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  idle_high_a: assert property (!tx_bit_valid |-> tx_bit)
    else $error("line not high while halted");
  bit_hold_a: assert property (tx_bit_valid && !tx_bit_ready |=> !tx_bit_valid || $stable(tx_bit))
    else $error("line bit changed without a take");
endmodule

// File: hdtx_framer_model.sv
// Behavioural line framer: takes serial bits and logs them in order.
// Assumes the same clock as the block; slow mode stalls every other cycle.
`timescale 1ns/10ps
module hdtx_framer_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic tx_bit_ready
);
  logic pace;
  bit log_q[$];
  always @(posedge aclk) begin
    if (!aresetn) begin
      pace <= 1'b0;
      tx_bit_ready <= 1'b0;
    end else begin
      pace <= ~pace;
      tx_bit_ready <= !slow || pace;
      if (tx_bit_ready && tx_bit_valid) begin
        log_q.push_back(tx_bit);
      end
    end
  end
endmodule

// File: hdlc_transmit_packet_fifo_tb_top.sv
// Self-checking bench: register tests over AXI4-Lite and line bit checks.
// Assumes the framer model logs every taken bit; expectations built here.
`timescale 1ns/10ps
`include "hdtx_defs.svh"
module hdlc_transmit_packet_fifo_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  // Response ready stays high so back-to-back calls never drive it twice in one step
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic tx_bit_ready, tx_bit, tx_bit_valid, irq, hit;
  int mismatches = 0, compares = 0, cycles = 0;
  bit want[$];
  logic [7:0] pkt[3] = '{8'h7E, 8'hF8, 8'h5A};
  logic [15:0] modes[6] = '{16'h0800, 16'h0808, 16'h0802, 16'h0820, 16'h0804, 16'h0822};
  localparam logic [11:0] A_CTL = 12'h280, A_PORT = 12'h288, A_STAT = 12'h290, A_LAT = 12'h298;
  localparam logic [11:0] A_IEN = 12'h2A0, A_GIE = 12'h2A8;
  // Short power-up keeps the post-reset discard window of 8 cycles inside the 12-cycle wait after reset
  hdtx_packet_fifo #(.FIFO_DEPTH(256), .POWERUP_CYCLES(8)) u_hdtx_packet_fifo (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bit_ready, .tx_bit, .tx_bit_valid, .irq);
  hdtx_framer_model u_hdtx_framer_model (.aclk, .aresetn, .slow, .tx_bit, .tx_bit_valid, .tx_bit_ready);
  always #4 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        resp = s_axi_bresp;
      end
    end
  endtask
  task automatic rd_reg(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask
  task automatic push_flag();
    logic [7:0] f;
    f = `HDTX_FLAG;
    for (int j = 0; j < 8; j++) want.push_back(f[j]);
  endtask
  task automatic build(input logic [15:0] ctl);
    logic [15:0] crc;
    bit raw[$];
    int ones;
    bit x;
    crc = `HDTX_CRC_PRESET;
    ones = 0;
    for (int i = 0; i < 24; i++) begin
      x = ctl[3] ? pkt[i / 8][7 - i % 8] : pkt[i / 8][i % 8];
      raw.push_back(x);
      crc = (crc[0] ^ x) ? (crc >> 1) ^ `HDTX_CRC_POLY : crc >> 1;
    end
    for (int i = 0; i < 16 && !ctl[1]; i++) raw.push_back(ctl[5] ? crc[i] : !crc[i]);
    want.delete();
    push_flag();
    foreach (raw[i]) begin
      want.push_back(raw[i]);
      ones = raw[i] ? ones + 1 : 0;
      if (ones == 5) begin
        want.push_back(1'b0);
        ones = 0;
      end
    end
    push_flag();
    foreach (want[i]) want[i] = want[i] ^ ctl[2];
  endtask
  task automatic seek();
    int k;
    hit = 1'b0;
    for (int s = 0; s + want.size() <= u_hdtx_framer_model.log_q.size(); s++) begin
      k = 0;
      while (k < want.size() && u_hdtx_framer_model.log_q[s + k] == want[k]) k++;
      if (k == want.size()) hit = 1'b1;
    end
  endtask
  task automatic send_pkt();
    wr(A_PORT, {pkt[0], 8'h00}, 4'h3);
    wr(A_PORT, {pkt[1], 8'h00}, 4'h3);
    wr(A_PORT, 16'h0001, 4'h1);
    wr(A_PORT, {pkt[2], 8'h00}, 4'h2);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
    rchk(A_CTL, 32'h00000800);
    rchk(A_PORT, 32'h00000000);
    rchk(A_STAT, 32'h00002003);
    rchk(A_IEN, 32'h00000000);
    rd_reg(12'h2AC);
    chk(resp, 2'h2);
    wr(12'h2AC, 16'h0000, 4'h3);
    chk(resp, 2'h2);
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, i == 0 ? 16'h0800 : (i == 1 ? 16'h0810 : 16'h0814), 4'h3);
      repeat (20) @(posedge aclk);
      u_hdtx_framer_model.log_q.delete();
      repeat (40) @(posedge aclk);
      want.delete();
      if (i == 0) push_flag();
      else repeat (16) want.push_back(i == 1);
      seek();
      chk(hit, 1'b1);
    end
    // Start disable keeps the processor from draining while the FIFO fills
    wr(A_CTL, 16'h0840, 4'h3);
    for (int n = 1; n <= 257; n++) begin
      wr(A_PORT, 16'h5500, 4'h3);
      if (n == 1) rchk(A_STAT, 32'h00001F01);
      if (n == 191) rchk(A_STAT, 32'h00000801);
      if (n == 192) rchk(A_STAT, 32'h00000800);
      if (n == 255) rchk(A_STAT, 32'h00000000);
      if (n == 256) rchk(A_STAT, 32'h00000004);
    end
    rd_reg(A_LAT);
    chk(rd & 32'h20, 32'h20);
    // Port enable alone must not raise the request; the condition enable is needed too
    wr(A_GIE, 16'h0001, 4'h3);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(A_IEN, 16'h0020, 4'h3);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    wr(A_GIE, 16'h0000, 4'h3);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(A_CTL, 16'h0841, 4'h3);
    @(posedge aclk);
    chk(tx_bit_valid, 1'b0);
    rchk(A_STAT, 32'h00002003);
    wr(A_PORT, 16'h1101, 4'h3);
    wr(A_LAT, 16'h003F, 4'h1);
    rchk(A_STAT, 32'h00002003);
    wr(A_CTL, 16'h0840, 4'h3);
    wr(A_PORT, 16'h2201, 4'h3);
    rd_reg(A_LAT);
    chk(rd & 32'h03, 32'h03);
    rchk(A_STAT, 32'h00002003);
    repeat (10) @(posedge aclk);
    u_hdtx_framer_model.log_q.delete();
    send_pkt();
    repeat (200) @(posedge aclk);
    build(16'h0800);
    seek();
    chk(hit, 1'b0);
    foreach (modes[m]) begin
      slow <= m[0];
      wr(A_CTL, modes[m], 4'h3);
      repeat (20) @(posedge aclk);
      u_hdtx_framer_model.log_q.delete();
      send_pkt();
      repeat (400) @(posedge aclk);
      build(modes[m]);
      seek();
      chk(hit, 1'b1);
      rchk(A_STAT, 32'h00002003);
    end
    // One byte with no end marker starves the processor mid-packet
    wr(A_LAT, 16'h003F, 4'h1);
    wr(A_PORT, 16'hA500, 4'h3);
    repeat (100) @(posedge aclk);
    rd_reg(A_LAT);
    chk(rd & 32'h18, 32'h10);
    report_and_stop();
  end
endmodule
bind hdtx_packet_fifo hdtx_checker u_hdtx_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tx_bit_ready, .tx_bit, .tx_bit_valid, .irq);
